// [rtl/tcc_pkg.sv]
// constants and types shared by the timer channel capture/compare block
// assumes an apb master and an external shared counter and prescaler
package tcc_pkg;

  localparam int NCH = 6;
  localparam int NPAIR = 3;
  localparam int ADDR_W = 12;

  // register map: one 16-byte slot per channel, index in paddr[6:4]
  localparam int CH_SHIFT = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_VHI = 4'h4;
  localparam logic [3:0] OFF_VLO = 4'h8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int FLAG_BIT = 7;

  // edge/level codes, capture meaning / compare meaning
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
  localparam logic [1:0] ELS_ANY_SET = 2'h3;

  typedef struct packed {
    logic channel_event_flag;
    logic channel_irq_enable;
    logic buffered_mode_select;
    logic function_select_bit;
    logic edge_level_select_high;
    logic edge_level_select_low;
    logic overflow_toggle_enable;
    logic full_duty_force;
  } tcc_ctrl_t;

  // view of the shared counter
  typedef struct packed {
    logic [15:0] count;
    logic overflow;
    logic counter_halt;
  } tcc_timer_t;

  typedef enum {
    MODE_OFF,
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_BUFFERED
  } tcc_mode_t;

endpackage : tcc_pkg

// [rtl/tcc_top.sv]
// six-channel capture/compare/pwm logic of a 16-bit timer, apb slave
// assumes the counter, prescaler and modulo logic sit outside and that
// timer_in.overflow pulses once as the counter wraps from modulo to zero
`timescale 1ns/1ps
`default_nettype none

// How it works
// - capture edge sets flag, latches counter
// - counter equals value sets flag
// - clear flag by read then write zero
// - event after read keeps flag set
// - reset clears flag; writing one ignored
// - irq when enable and flag; reset clears
// - buffer bit only on even channels
// - buffering disables odd partner and pin
// - function bit picks compare or capture
// - edge field zero: function bit presets level
// - edge field zero leaves pin to port
// - capture edges: rise, fall, either
// - compare actions: toggle, clear, set
// - buffer bit forces buffered compare
// - overflow toggle only for compare channels
// - overflow action beats compare action
// - full duty takes effect next period
// - value registers hold capture or compare
// - high byte read blocks capture
// - high byte write blocks compare, odd buffer half only if its function bit is set
// - overflow is wrap from modulo to zero
module tcc_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shared counter
  input wire tcc_pkg::tcc_timer_t timer_in,
  // channel pins
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_n,
  // interrupt requests
  output logic [5:0] irq_req
);

  tcc_pkg::tcc_ctrl_t ctrl_reg [6];
  logic [15:0] value_reg [6];
  logic [5:0] arm_reg, rlock_reg, wlock_reg, pin_prev_reg, match_prev_reg;
  logic [5:0] out_reg, oe_n_reg, irq_reg, full_eff_reg;
  logic [2:0] active_odd_reg, last_odd_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;

  function automatic logic [1:0] els_of(input tcc_pkg::tcc_ctrl_t c);
    return {c.edge_level_select_high, c.edge_level_select_low};
  endfunction : els_of

  function automatic tcc_pkg::tcc_mode_t mode_of(
    input tcc_pkg::tcc_ctrl_t c,
    input logic disabled
  );
    if (disabled || els_of(c) == tcc_pkg::ELS_OFF) begin
      return tcc_pkg::MODE_OFF;
    end else if (c.buffered_mode_select) begin
      return tcc_pkg::MODE_BUFFERED;
    end else if (c.function_select_bit) begin
      return tcc_pkg::MODE_COMPARE;
    end
    return tcc_pkg::MODE_CAPTURE;
  endfunction : mode_of

  // level a pwm stays at when forced to full duty
  function automatic logic full_level(input logic [1:0] els);
    return els != tcc_pkg::ELS_ANY_SET;
  endfunction : full_level

  // apb decode
  logic access, wr_do, rd_do, addr_ok;
  logic [2:0] ch_idx;
  logic [3:0] slot;
  assign ch_idx = paddr[6:4];
  assign slot = paddr[3:0];
  assign addr_ok = (paddr[tcc_pkg::ADDR_W-1:7] == '0)
                 && (ch_idx < 3'h6)
                 && (slot == tcc_pkg::OFF_CTRL || slot == tcc_pkg::OFF_VHI
                     || slot == tcc_pkg::OFF_VLO);
  // effects happen only at the edge where pready is sampled high
  assign access = psel && penable && pready_reg;
  assign wr_do = access && pwrite && addr_ok;
  assign rd_do = access && !pwrite && addr_ok;

  // per-channel decode
  tcc_pkg::tcc_mode_t mode [6];
  logic [5:0] disabled, cap_evt, cmp_evt, drives, wr_ctrl, rd_ctrl;
  logic [5:0] wr_hi, wr_lo, rd_hi, rd_lo, cmp_lock;
  logic [15:0] cmp_val [6];
  logic edge_seen;

  always_comb begin
    edge_seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      disabled[i] = (i % 2 == 1)
        && ctrl_reg[i - (i % 2)].buffered_mode_select;
      mode[i] = mode_of(ctrl_reg[i], disabled[i]);
      wr_ctrl[i] = wr_do && ch_idx == 3'(i) && slot == tcc_pkg::OFF_CTRL;
      wr_hi[i] = wr_do && ch_idx == 3'(i) && slot == tcc_pkg::OFF_VHI;
      wr_lo[i] = wr_do && ch_idx == 3'(i) && slot == tcc_pkg::OFF_VLO;
      rd_ctrl[i] = rd_do && ch_idx == 3'(i) && slot == tcc_pkg::OFF_CTRL;
      rd_hi[i] = rd_do && ch_idx == 3'(i) && slot == tcc_pkg::OFF_VHI;
      rd_lo[i] = rd_do && ch_idx == 3'(i) && slot == tcc_pkg::OFF_VLO;
      // buffered even channels compare against whichever half is active
      // i | 1 names the odd partner and stays in range for every channel
      if (mode[i] == tcc_pkg::MODE_BUFFERED && active_odd_reg[i / 2]) begin
        cmp_val[i] = value_reg[i | 1];
      end else begin
        cmp_val[i] = value_reg[i];
      end
      cmp_lock[i] = wlock_reg[i]
        || (mode[i] == tcc_pkg::MODE_BUFFERED && wlock_reg[i | 1]);
      case (els_of(ctrl_reg[i]))
        tcc_pkg::ELS_RISE_TOGGLE: edge_seen = pin_in[i] && !pin_prev_reg[i];
        tcc_pkg::ELS_FALL_CLEAR: edge_seen = !pin_in[i] && pin_prev_reg[i];
        tcc_pkg::ELS_ANY_SET: edge_seen = pin_in[i] != pin_prev_reg[i];
        default: edge_seen = 1'b0;
      endcase
      // halted counter and a pending high-byte read both hold captures
      cap_evt[i] = mode[i] == tcc_pkg::MODE_CAPTURE && edge_seen
        && !timer_in.counter_halt && !rlock_reg[i];
      // match fires once as the counter arrives at the value
      cmp_evt[i] = (mode[i] == tcc_pkg::MODE_COMPARE
                    || mode[i] == tcc_pkg::MODE_BUFFERED)
        && timer_in.count == cmp_val[i] && !match_prev_reg[i]
        && !cmp_lock[i];
      drives[i] = mode[i] == tcc_pkg::MODE_COMPARE
               || mode[i] == tcc_pkg::MODE_BUFFERED;
    end
  end

  // control registers and event flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 6; i++) begin
        ctrl_reg[i] <= tcc_pkg::CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (wr_ctrl[i] && !disabled[i]) begin
          ctrl_reg[i] <= pwdata[7:0];
          ctrl_reg[i].buffered_mode_select <= (i % 2 == 0)
            && pwdata[5];
          // only a zero after an armed read clears; a one never does
          ctrl_reg[i].channel_event_flag <= ctrl_reg[i].channel_event_flag
            && !(arm_reg[i] && !pwdata[tcc_pkg::FLAG_BIT]);
        end
        // a new event wins over any clear in the same cycle
        if (cap_evt[i] || cmp_evt[i]) begin
          ctrl_reg[i].channel_event_flag <= 1'b1;
        end
      end
    end
  end

  // clear-sequence arming: read with flag set, broken by any new event
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arm_reg <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (cap_evt[i] || cmp_evt[i]) begin
          arm_reg[i] <= 1'b0;
        end else if (rd_ctrl[i] && ctrl_reg[i].channel_event_flag) begin
          arm_reg[i] <= 1'b1;
        end else if (wr_ctrl[i]) begin
          arm_reg[i] <= 1'b0;
        end
      end
    end
  end

  // byte coherency locks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rlock_reg <= 6'h00;
      wlock_reg <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (rd_lo[i]) begin
          rlock_reg[i] <= 1'b0;
        end else if (rd_hi[i] && !ctrl_reg[i].buffered_mode_select
                     && !ctrl_reg[i].function_select_bit) begin
          rlock_reg[i] <= 1'b1;
        end
        if (wr_lo[i]) begin
          wlock_reg[i] <= 1'b0;
        end else if (wr_hi[i] && (ctrl_reg[i].buffered_mode_select
                                  || ctrl_reg[i].function_select_bit)) begin
          wlock_reg[i] <= 1'b1;
        end
      end
    end
  end

  // value registers carry no reset: their content is undefined until used
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (wr_hi[i]) begin
        value_reg[i][15:8] <= pwdata[7:0];
      end else if (wr_lo[i]) begin
        value_reg[i][7:0] <= pwdata[7:0];
      end else if (cap_evt[i]) begin
        value_reg[i] <= timer_in.count;
      end
    end
  end

  // buffered pairs: last completed write decides the next period's value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_odd_reg <= 3'h0;
      active_odd_reg <= 3'h0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (wr_lo[2 * p]) begin
          last_odd_reg[p] <= 1'b0;
        end else if (wr_lo[2 * p + 1]) begin
          last_odd_reg[p] <= 1'b1;
        end
        if (timer_in.overflow) begin
          active_odd_reg[p] <= last_odd_reg[p];
        end
      end
    end
  end

  // channel output level and pin drive
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_reg <= 6'h00;
      oe_n_reg <= 6'h3F;
      full_eff_reg <= 6'h00;
      pin_prev_reg <= 6'h00;
      match_prev_reg <= 6'h00;
    end else begin
      pin_prev_reg <= pin_in;
      for (int i = 0; i < 6; i++) begin
        match_prev_reg[i] <= timer_in.count == cmp_val[i];
        // full duty changes only at a period boundary
        if (timer_in.overflow) begin
          full_eff_reg[i] <= ctrl_reg[i].full_duty_force;
        end
        oe_n_reg[i] <= !drives[i];
        if (mode[i] == tcc_pkg::MODE_OFF) begin
          out_reg[i] <= !ctrl_reg[i].function_select_bit;
        end else if (!drives[i]) begin
          out_reg[i] <= out_reg[i];
        end else if (ctrl_reg[i].overflow_toggle_enable
                     && full_eff_reg[i]) begin
          out_reg[i] <= full_level(els_of(ctrl_reg[i]));
        end else if (ctrl_reg[i].overflow_toggle_enable
                     && timer_in.overflow) begin
          out_reg[i] <= !out_reg[i];
        end else if (cmp_evt[i]) begin
          case (els_of(ctrl_reg[i]))
            tcc_pkg::ELS_RISE_TOGGLE: out_reg[i] <= !out_reg[i];
            tcc_pkg::ELS_FALL_CLEAR: out_reg[i] <= 1'b0;
            tcc_pkg::ELS_ANY_SET: out_reg[i] <= 1'b1;
            default: out_reg[i] <= out_reg[i];
          endcase
        end
      end
    end
  end

  // interrupt requests
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_reg <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        irq_reg[i] <= ctrl_reg[i].channel_irq_enable
          && ctrl_reg[i].channel_event_flag && !disabled[i];
      end
    end
  end

  // apb response: one wait state, then pready for a single cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !addr_ok;
      prdata_reg <= 32'h0000_0000;
      if (psel && penable && !pready_reg && !pwrite && addr_ok) begin
        case (slot)
          tcc_pkg::OFF_CTRL: prdata_reg[7:0] <= disabled[ch_idx]
            ? 8'h00 : ctrl_reg[ch_idx];
          tcc_pkg::OFF_VHI: prdata_reg[7:0] <= value_reg[ch_idx][15:8];
          tcc_pkg::OFF_VLO: prdata_reg[7:0] <= value_reg[ch_idx][7:0];
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = out_reg;
  assign pin_oe_n = oe_n_reg;
  assign irq_req = irq_reg;

endmodule : tcc_top

`default_nettype wire

// [tb/tcc_sva.sv]
// assertions on the apb and pin ports of the capture/compare block
// assumes a single clock and the one-wait-state slave of the design
`timescale 1ns/1ps
`default_nettype none
module tcc_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // channel side
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] irq_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  ready_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  ready_idle_a: assert property (!(psel && penable) |-> !pready)
    else $error("ready outside access");
  rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  rdata_byte_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  irq_clear_a: assert property ($fell(irq_req[0]) |->
    $past(wr_done, 1) || $past(wr_done, 2))
    else $error("request dropped without a write");
  oe_write_a: assert property ($changed(pin_oe_n) |->
    $past(wr_done, 1) || $past(wr_done, 2))
    else $error("pin drive changed without a write");
endmodule : tcc_sva
bind tcc_top tcc_sva u_sva (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_oe_n(pin_oe_n), .irq_req(irq_req));
`default_nettype wire

// [tb/tcc_cnt_model.sv]
// shared counter seen by the channels: counts while run, wraps at MODV
// assumes the bench drives run and halt from the clock's rising edge
`timescale 1ns/1ps
`default_nettype none
module tcc_cnt_model #(
  parameter logic [15:0] MODV = 16'h01FF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bench control
  input wire logic run,
  input wire logic halt,
  // counter view
  output var tcc_pkg::tcc_timer_t tmr
);
  logic [15:0] count_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      count_reg <= 16'h0000;
    else if (run)
      count_reg <= (count_reg == MODV) ? 16'h0000 : count_reg + 16'h0001;
  end
  assign tmr.count = count_reg;
  assign tmr.overflow = run && (count_reg == MODV);
  assign tmr.counter_halt = halt;
endmodule : tcc_cnt_model
`default_nettype wire

// [tb/tcc_top_test.sv]
// self-checking bench: apb tasks, pin edges and a modulo counter model
// assumes the register map of the package: channel n at 0x10*n
`timescale 1ns/1ps
`default_nettype none
module tcc_top_test;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, run, halt, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cap;
  logic [7:0] cv;
  logic p0;
  logic [5:0] pin_in, pin_out, pin_oe_n, irq_req;
  tcc_pkg::tcc_timer_t timer_in;
  int n_errors, n_checks;
  tcc_top uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .irq_req(irq_req));
  tcc_cnt_model cnt (.clk(clk), .reset(reset), .run(run), .halt(halt),
    .tmr(timer_in));
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // request held until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (k >= 20)
      n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic clr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b0, a, 32'h0);
    apb(1'b1, a, {24'h0, v});
  endtask : clr
  task automatic pin(input logic v);
    @(posedge clk);
    pin_in[0] <= v;
    repeat (3) @(posedge clk);
  endtask : pin
  task automatic tick(input int n);
    @(posedge clk);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    // let the last count settle before anyone samples it
    @(posedge clk);
  endtask : tick
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (12000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    {reset, psel, penable, pwrite, run, halt} = 6'h20;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin_in = 6'h00;
    n_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pin_oe_n, 6'h3F);
    chk(pin_out, 6'h3F);
    rdc(12'h000, 32'h0);
    rdc(12'h060, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 12'h010, 32'h20);
    rdc(12'h010, 32'h0);
    apb(1'b1, 12'h010, 32'h10);
    repeat (2) @(posedge clk);
    chk({pin_out[1], pin_oe_n[1]}, 2'b01);
    tick(300);
    cap = timer_in.count;
    for (int e = 1; e < 4; e++) begin
      cv = 8'(32'h40 | (e << 2));
      apb(1'b1, 12'h000, {24'h0, cv});
      pin(1'b1);
      rdc(12'h000, cv | (e[0] << 7));
      clr(12'h000, cv);
      pin(1'b0);
      rdc(12'h000, cv | (e[1] << 7));
      clr(12'h000, cv);
    end
    pin(1'b1);
    chk(irq_req[0], 1'b1);
    rdc(12'h004, cap[15:8]);
    rdc(12'h008, cap[7:0]);
    apb(1'b1, 12'h000, 32'h4C);
    rdc(12'h000, 32'hCC);
    apb(1'b0, 12'h000, 32'h0);
    pin(1'b0);
    apb(1'b1, 12'h000, 32'h4C);
    rdc(12'h000, 32'hCC);
    clr(12'h000, 8'h4C);
    rdc(12'h000, 32'h4C);
    chk(irq_req[0], 1'b0);
    apb(1'b1, 12'h000, 32'hCC);
    rdc(12'h000, 32'h4C);
    rdc(12'h004, cap[15:8]);
    pin(1'b1);
    rdc(12'h000, 32'h4C);
    rdc(12'h008, cap[7:0]);
    pin(1'b0);
    rdc(12'h000, 32'hCC);
    apb(1'b1, 12'h020, 32'h14);
    apb(1'b1, 12'h024, 32'h01);
    apb(1'b1, 12'h028, 32'h40);
    repeat (2) @(posedge clk);
    p0 = pin_out[2];
    tick(40);
    repeat (2) @(posedge clk);
    chk({pin_out[2] ^ p0, pin_oe_n[2]}, 2'b10);
    rdc(12'h020, 32'h94);
    clr(12'h020, 8'h14);
    apb(1'b1, 12'h024, 32'h01);
    tick(520);
    rdc(12'h020, 32'h14);
    apb(1'b1, 12'h028, 32'h40);
    tick(520);
    rdc(12'h020, 32'h94);
    apb(1'b1, 12'h000, 32'h24);
    apb(1'b1, 12'h010, 32'h10);
    rdc(12'h010, 32'h0);
    repeat (2) @(posedge clk);
    chk({pin_oe_n[0], pin_oe_n[1]}, 2'b01);
    give_verdict();
  end
endmodule : tcc_top_test
`default_nettype wire
